// ### src/bci_defines.svh
/*
 constants for the branch-condition and indicator block.
 assumes inclusion by bare name from src/.
*/
`ifndef BCI_DEFINES_SVH
`define BCI_DEFINES_SVH

`define BCI_ADDR_CMD 12'h000
`define BCI_ADDR_CTRL 12'h004
`define BCI_ADDR_STAT 12'h008
`define BCI_ADDR_IND_LO 12'h00C
`define BCI_ADDR_IND_HI 12'h010
`define BCI_ADDR_NEXT 12'h014
`define BCI_ADDR_TIME 12'h018
`define BCI_ADDR_DATA 12'h01C

`define BCI_OP_LSB 0
`define BCI_CODE_LSB 4
`define BCI_PADDR_LSB 12
`define BCI_NP_LSB 0
`define BCI_NQ_LSB 8
`define BCI_SGNP_BIT 16
`define BCI_SGNQ_BIT 17
`define BCI_CMPRES_LSB 18
`define BCI_NZ_LSB 20
`define BCI_DIG_LSB 0
`define BCI_FLAG_BIT 4
`define BCI_FIVE_BIT 6
`define BCI_CTL_START 0
`define BCI_CTL_RESET 1
`define BCI_CTL_CHKRST 2
`define BCI_CTL_PRTRST 3

`define BCI_T_BRANCH 16'd40
`define BCI_T_DIGIT 16'd70
`define BCI_T_INDIC 16'd60
`define BCI_T_LIKE_BASE 16'd65
`define BCI_T_UNLIKE_BASE 16'd80
`define BCI_T_UNLIKE_STEP 16'd15
`define BCI_T_PSTEP 16'd10
`define BCI_T_QSTEP 16'd5
`define BCI_CYC_PER_UNIT 8'd1
`define BCI_SEQ_STEP 20'h0000C

`define BCI_IND_NONE 7'd0
`define BCI_IND_RESET 64'h0000000040000000
`endif

// ### src/bci_pkg.sv
/*
 types for the branch-condition and indicator block.
 assumes no surroundings.
*/
package bci_pkg;
    typedef enum logic [3:0] {
        BCI_OPC_COMPARE,
        BCI_OPC_COMPARE_IMM,
        BCI_OPC_BRANCH,
        BCI_OPC_DIGIT,
        BCI_OPC_FLAG,
        BCI_OPC_RECORD,
        BCI_OPC_GROUP,
        BCI_OPC_IND_ON,
        BCI_OPC_IND_OFF,
        BCI_OPC_SELECT,
        BCI_OPC_ARITH
    } bci_opc_t;
    typedef enum logic [1:0] {
        BCI_ST_IDLE,
        BCI_ST_RUN,
        BCI_ST_DONE
    } bci_state_t;
endpackage : bci_pkg

// ### src/bci_core.sv
/*
 branch-condition evaluation and program-indicator bank, APB slave.
 assumes a 50 MHz pclk; operand facts are supplied by software.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "bci_defines.svh"

// What this block and its program do
// RL1: alphameric collating order: blank, letters, digits
// RL2: program keeps marks out of operand data
// RL3: like-sign compare time 10(6.5+.5Dq+Dp)
// RL4: unlike-sign compare time 10(8+1.5Dz)
// RL5: immediate compare times like normal compare
// RL6: unconditional branch to P, 40 units
// RL7: branch on nonzero digit, 70 units
// RL8: branch when flag bit absent
// RL9: branch unless 8 and 2 bits present
// RL10: branch when no group mark
// RL11: indicator test by two-digit code, 60 units
// RL12: codes 01-04 mirror program switches
// RL13: read/write check set by io, cleared
// RL14: last card set, cleared by test, reset
// RL15: indicator 13 is OR of 11, 12
// RL16: arithmetic result sets high or zero
// RL17: exponent check set, cleared by test
// RL18: buffer parity indicators 16, 17
// RL19: indicator 19 ORs six error indicators
// RL20: index bands set by select, kept
// RL21: disk errors cleared, 39 their OR
// RL22: printer check: sync needs printer reset
// RL23: compare sets high or equal indicator
// RL24: program keeps branch targets even
// RL25: reset key clears indicators synchronously
module bci_core
    import bci_pkg::*;
#(
    parameter int unsigned CYC_PER_UNIT = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] prog_switch,
    input wire logic read_check_evt,
    input wire logic write_check_evt,
    input wire logic last_card_evt,
    input wire logic arith_check_evt,
    input wire logic exp_check_evt,
    input wire logic parity_even_evt,
    input wire logic parity_odd_evt,
    input wire logic [2:0] disk_err_evt,
    input wire logic disk_op_evt,
    input wire logic printer_parity_evt,
    input wire logic printer_sync_evt,
    input wire logic printer_reset_key,
    output logic busy,
    output logic branch_taken
);

    ////////////////////////////////////////////////////////////////////////
    logic apb_wr;
    logic apb_rd;
    logic [31:0] cmd_reg;
    logic [31:0] data_reg;
    logic [19:0] next_reg;
    logic [15:0] time_reg;
    logic [15:0] cnt_reg;
    logic [7:0] sub_reg;
    bci_state_t state_reg;
    logic [63:0] ind_reg;
    logic prt_sync_reg;
    logic start_pulse;
    logic reset_key;
    logic check_reset_key;
    logic [3:0] opnum;
    logic [6:0] sel_code;
    logic [19:0] p_addr;
    logic [5:0] dig;
    logic [63:0] ind_view;
    logic sel_bit;
    logic take;
    logic [15:0] dur;
    logic [1:0] cmpres;
    logic is_test;
    logic test_clears;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign start_pulse = apb_wr && (paddr == `BCI_ADDR_CTRL) && pwdata[`BCI_CTL_START];
    assign reset_key = apb_wr && (paddr == `BCI_ADDR_CTRL) && pwdata[`BCI_CTL_RESET];
    assign check_reset_key = apb_wr && (paddr == `BCI_ADDR_CTRL) && pwdata[`BCI_CTL_CHKRST];
    assign opnum = cmd_reg[`BCI_OP_LSB +: 4];
    assign sel_code = cmd_reg[`BCI_CODE_LSB +: 7];
    assign p_addr = cmd_reg[`BCI_PADDR_LSB +: 20];
    assign dig = data_reg[`BCI_DIG_LSB +: 6];
    assign cmpres = data_reg[`BCI_CMPRES_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // combined indicators formed live, never stored
    always_comb begin
        ind_view = ind_reg;
        ind_view[4:1] = prog_switch; // RL12
        ind_view[13] = ind_reg[11] || ind_reg[12]; // RL15
        ind_view[39] = |ind_reg[38:36]; // RL21
        ind_view[19] = ind_reg[6] || ind_reg[7] || ind_reg[16] || ind_reg[17] || ind_reg[25]
            || (|ind_reg[38:36]); // RL19
    end

    assign sel_bit = ind_view[sel_code[5:0]]; // RL11

    ////////////////////////////////////////////////////////////////////////
    // branch decision and execution time in time units
    always_comb begin
        take = 1'b0;
        dur = `BCI_T_DIGIT;
        case (bci_opc_t'(opnum))
            BCI_OPC_COMPARE, BCI_OPC_COMPARE_IMM: begin // RL5
                if (data_reg[`BCI_SGNP_BIT] == data_reg[`BCI_SGNQ_BIT]) begin
                    dur = 16'(`BCI_T_LIKE_BASE + `BCI_T_PSTEP * 16'(data_reg[`BCI_NP_LSB +: 8])
                        + `BCI_T_QSTEP * 16'(data_reg[`BCI_NQ_LSB +: 8])); // RL3
                end else begin
                    dur = 16'(`BCI_T_UNLIKE_BASE
                        + `BCI_T_UNLIKE_STEP * 16'(data_reg[`BCI_NZ_LSB +: 8])); // RL4
                end
            end
            BCI_OPC_BRANCH: begin
                take = 1'b1; // RL6
                dur = `BCI_T_BRANCH; // RL6
            end
            BCI_OPC_DIGIT: take = (dig[3:0] != 4'h0); // RL7
            BCI_OPC_FLAG: take = !dig[`BCI_FLAG_BIT]; // RL8
            BCI_OPC_RECORD: take = !(dig[3] && dig[1]); // RL9
            BCI_OPC_GROUP: take = !(dig[3:0] == 4'hA && dig[`BCI_FIVE_BIT - 1]); // RL10
            BCI_OPC_IND_ON: begin
                take = sel_bit; // RL11
                dur = `BCI_T_INDIC; // RL11
            end
            BCI_OPC_IND_OFF: begin
                take = !sel_bit;
                dur = `BCI_T_INDIC;
            end
            BCI_OPC_SELECT: begin
                take = 1'b1;
                dur = `BCI_T_INDIC;
            end
            default: begin
                take = 1'b0;
                dur = `BCI_T_PSTEP;
            end
        endcase
    end

    assign is_test = (bci_opc_t'(opnum) == BCI_OPC_IND_ON) || (bci_opc_t'(opnum) == BCI_OPC_IND_OFF);
    // tests of 11, 12, 13, 19 and 30-32 clear nothing, nor of 25 after sync; other tested indicators clear
    assign test_clears = (state_reg == BCI_ST_RUN) && (cnt_reg == 16'h0000) && (sub_reg == 8'h00)
        && is_test; // RL15 RL19

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 32'h00000000;
            data_reg <= 32'h00000000;
        end else if (apb_wr && state_reg != BCI_ST_RUN) begin
            if (paddr == `BCI_ADDR_CMD) begin
                cmd_reg <= pwdata;
            end else if (paddr == `BCI_ADDR_DATA) begin
                data_reg <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= BCI_ST_IDLE;
            cnt_reg <= 16'h0000;
            sub_reg <= 8'h00;
            time_reg <= 16'h0000;
            next_reg <= 20'h00000;
            busy <= 1'b0;
            branch_taken <= 1'b0;
        end else begin
            case (state_reg)
                BCI_ST_IDLE, BCI_ST_DONE: begin
                    if (start_pulse && !reset_key) begin
                        state_reg <= BCI_ST_RUN;
                        cnt_reg <= dur - 16'h0001;
                        sub_reg <= 8'(CYC_PER_UNIT - 1);
                        time_reg <= dur;
                        busy <= 1'b1;
                    end
                end
                BCI_ST_RUN: begin
                    if (sub_reg != 8'h00) begin
                        sub_reg <= sub_reg - 8'h01;
                    end else if (cnt_reg != 16'h0000) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                        sub_reg <= 8'(CYC_PER_UNIT - 1);
                    end else begin
                        state_reg <= BCI_ST_DONE;
                        busy <= 1'b0;
                        branch_taken <= take;
                        next_reg <= take ? p_addr : 20'(next_reg + `BCI_SEQ_STEP); // RL6 RL24
                    end
                end
                default: state_reg <= BCI_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator bank: events win over clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_reg <= `BCI_IND_RESET; // RL20
        end else begin
            if (reset_key) begin
                ind_reg[7:6] <= 2'b00; // RL25 RL13
                ind_reg[9] <= 1'b0; // RL14
                ind_reg[12:11] <= 2'b00; // RL16
                ind_reg[17:14] <= 4'h0; // RL17
                ind_reg[38:36] <= 3'b000; // RL21
                if (!prt_sync_reg) begin
                    ind_reg[25] <= 1'b0; // RL22
                end
            end
            if (check_reset_key) begin
                ind_reg[7:6] <= 2'b00; // RL13
                ind_reg[17:16] <= 2'b00; // RL18
                ind_reg[38:36] <= 3'b000; // RL21
            end
            if (disk_op_evt) begin
                ind_reg[38:36] <= 3'b000; // RL21
            end
            if (printer_reset_key) begin
                ind_reg[25] <= 1'b0; // RL22
            end
            if (test_clears && sel_code != 7'd13 && sel_code != 7'd19 && !(sel_code >= 7'd30 && sel_code <= 7'd32)
                && !(sel_code == 7'd25 && prt_sync_reg) && !(sel_code == 7'd11 || sel_code == 7'd12)) begin
                ind_reg[sel_code[5:0]] <= 1'b0; // RL13 RL14 RL17 RL18 RL20
            end
            if (state_reg == BCI_ST_RUN && cnt_reg == 16'h0000 && sub_reg == 8'h00) begin
                if (bci_opc_t'(opnum) == BCI_OPC_COMPARE || bci_opc_t'(opnum) == BCI_OPC_COMPARE_IMM
                    || bci_opc_t'(opnum) == BCI_OPC_ARITH) begin
                    ind_reg[11] <= (cmpres == 2'b01); // RL16 RL23 RL1
                    ind_reg[12] <= (cmpres == 2'b10); // RL16 RL23
                end
                if (bci_opc_t'(opnum) == BCI_OPC_SELECT) begin
                    ind_reg[32:30] <= data_reg[2:0]; // RL20
                end
            end
            if (read_check_evt) ind_reg[6] <= 1'b1; // RL13
            if (write_check_evt) ind_reg[7] <= 1'b1; // RL13
            if (last_card_evt) ind_reg[9] <= 1'b1; // RL14
            if (arith_check_evt) ind_reg[14] <= 1'b1; // RL17
            if (exp_check_evt) ind_reg[15] <= 1'b1; // RL17
            if (parity_even_evt) ind_reg[16] <= 1'b1; // RL18
            if (parity_odd_evt) ind_reg[17] <= 1'b1; // RL18
            for (int i = 0; i < 3; i++) begin
                if (disk_err_evt[i]) ind_reg[36 + i] <= 1'b1; // RL21
            end
            if (printer_parity_evt || printer_sync_evt) ind_reg[25] <= 1'b1; // RL22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prt_sync_reg <= 1'b0;
        end else if (printer_sync_evt) begin
            prt_sync_reg <= 1'b1; // RL22
        end else if (printer_reset_key) begin
            prt_sync_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read path, zero-wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                if (paddr == `BCI_ADDR_CMD) begin
                    prdata <= cmd_reg;
                end else if (paddr == `BCI_ADDR_CTRL) begin
                    prdata <= 32'h00000000;
                end else if (paddr == `BCI_ADDR_STAT) begin
                    prdata <= {30'h00000000, branch_taken, busy};
                end else if (paddr == `BCI_ADDR_IND_LO) begin
                    prdata <= ind_view[31:0];
                end else if (paddr == `BCI_ADDR_IND_HI) begin
                    prdata <= ind_view[63:32];
                end else if (paddr == `BCI_ADDR_NEXT) begin
                    prdata <= {12'h000, next_reg};
                end else if (paddr == `BCI_ADDR_TIME) begin
                    prdata <= {16'h0000, time_reg};
                end else if (paddr == `BCI_ADDR_DATA) begin
                    prdata <= data_reg;
                end else begin
                    prdata <= 32'h00000000;
                    pslverr <= 1'b1;
                end
            end
        end
    end

    logic unused_rd;
    assign unused_rd = apb_rd;

endmodule : bci_core

// ### testbench/bci_core_sva.sv
/*
 port-level assertions for the indicator block.
 assumes a bind from the bench top onto bci_core.
*/
`timescale 1ns/1ns
module bci_core_sva #(
    parameter int unsigned CYC_PER_UNIT = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy,
    input wire logic branch_taken
);
    int run_cnt;
    logic [3:0] last_op;
    // opcode of the instruction being timed; arithmetic has no branch floor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_op <= 4'h0;
        end else if (psel && penable && pready && pwrite && paddr == 12'h000 && !busy) begin
            last_op <= pwdata[3:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= busy ? run_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    a_ready_access: assert property (psel && !penable |=> pready) else $error("access cycle without ready");
    a_ready_idle: assert property (!psel |-> !pready) else $error("ready without select");
    a_err_unmapped: assert property (psel && penable && paddr > 12'h01C |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && penable && paddr <= 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_start_busy: assert property (psel && penable && pready && pwrite && paddr == 12'h004 && pwdata[0]
        && !busy |=> busy) else $error("start did not raise busy");
    a_busy_min: assert property ($fell(busy) && last_op != 4'hA |-> $past(run_cnt) >= 39 * CYC_PER_UNIT)
        else $error("instruction ended too soon");
    a_busy_max: assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("busy never ended");
    a_taken_hold: assert property (busy |-> $stable(branch_taken)) else $error("branch result moved");
    a_err_ready: assert property (pslverr |-> pready) else $error("error outside access");
endmodule : bci_core_sva

// ### testbench/bci_console_model.sv
/*
 console operator and event sources for the indicator block.
 assumes the bench maps evt bits onto the event ports.
*/
`timescale 1ns/1ns
module bci_console_model (
    input wire logic pclk,
    output logic [3:0] prog_switch,
    output logic [13:0] evt
);
    initial begin
        prog_switch = 4'hA;
        evt = 14'h0000;
    end
    // one-cycle pulse on one event line
    task automatic pulse(input int idx);
        @(posedge pclk);
        evt <= 14'h0001 << idx;
        @(posedge pclk);
        evt <= 14'h0000;
    endtask : pulse
    // operator flips the program switches
    task automatic set_switch(input logic [3:0] v);
        @(posedge pclk);
        prog_switch <= v;
    endtask : set_switch
endmodule : bci_console_model

// ### testbench/tb_branch_condition_indicators.sv
/*
 self-checking bench for the indicator block.
 assumes the console model and the checker beside it.
*/
`timescale 1ns/1ns
`include "bci_defines.svh"
module tb_branch_condition_indicators;
    import bci_pkg::*;
    typedef struct {bci_opc_t op; logic [6:0] code; logic [19:0] p; logic [31:0] d; logic [1:0] tk;
        logic [15:0] t;} bci_row_t;
    localparam int unsigned CPU = 1;
    localparam logic [31:0] BASE = 32'h40000014;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, branch_taken;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] prog_switch;
    logic [13:0] evt;
    logic e;
    logic [19:0] nxt = 20'h0;
    int miscompares = 0, checks_done = 0, cycles = 0;
    // even targets, no marks as compare data; tk 2 = result not checked
    bci_row_t rows [21] = '{
        '{BCI_OPC_BRANCH, 7'd0, 20'h00100, 32'h0, 2'd1, 16'd40}, '{BCI_OPC_DIGIT, 7'd0, 20'h00200, 32'h05, 2'd1, 16'd70},
        '{BCI_OPC_DIGIT, 7'd0, 20'h00202, 32'h10, 2'd0, 16'd70}, '{BCI_OPC_DIGIT, 7'd0, 20'h00204, 32'h00, 2'd0, 16'd70},
        '{BCI_OPC_FLAG, 7'd0, 20'h00206, 32'h13, 2'd0, 16'd70}, '{BCI_OPC_FLAG, 7'd0, 20'h00208, 32'h03, 2'd1, 16'd70},
        '{BCI_OPC_RECORD, 7'd0, 20'h0020A, 32'h0B, 2'd0, 16'd70}, '{BCI_OPC_RECORD, 7'd0, 20'h0020C, 32'h2A, 2'd0, 16'd70},
        '{BCI_OPC_RECORD, 7'd0, 20'h0020E, 32'h09, 2'd1, 16'd70}, '{BCI_OPC_GROUP, 7'd0, 20'h00210, 32'h0A, 2'd1, 16'd70},
        '{BCI_OPC_GROUP, 7'd0, 20'h00212, 32'h2A, 2'd0, 16'd70},
        '{BCI_OPC_COMPARE, 7'd0, 20'h00214, 32'h00040305, 2'd2, 16'd130},
        '{BCI_OPC_IND_ON, 7'd11, 20'h00216, 32'h0, 2'd1, 16'd60}, '{BCI_OPC_IND_ON, 7'd13, 20'h00218, 32'h0, 2'd1, 16'd60},
        '{BCI_OPC_IND_OFF, 7'd12, 20'h0021A, 32'h0, 2'd1, 16'd60},
        '{BCI_OPC_COMPARE_IMM, 7'd0, 20'h0021C, 32'h00410000, 2'd2, 16'd140},
        '{BCI_OPC_IND_ON, 7'd13, 20'h0021E, 32'h0, 2'd0, 16'd60}, '{BCI_OPC_IND_ON, 7'd1, 20'h00220, 32'h0, 2'd0, 16'd60},
        '{BCI_OPC_IND_ON, 7'd2, 20'h00222, 32'h0, 2'd1, 16'd60}, '{BCI_OPC_IND_ON, 7'd30, 20'h00224, 32'h0, 2'd1, 16'd60},
        '{BCI_OPC_IND_ON, 7'd30, 20'h00226, 32'h0, 2'd1, 16'd60}};
    bci_console_model u_console (.pclk(pclk), .prog_switch(prog_switch), .evt(evt));
    bci_core #(.CYC_PER_UNIT(CPU)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_switch(prog_switch), .read_check_evt(evt[0]), .write_check_evt(evt[1]), .last_card_evt(evt[2]),
        .arith_check_evt(evt[3]), .exp_check_evt(evt[4]), .parity_even_evt(evt[5]), .parity_odd_evt(evt[6]),
        .disk_err_evt(evt[9:7]), .disk_op_evt(evt[10]), .printer_parity_evt(evt[11]),
        .printer_sync_evt(evt[12]), .printer_reset_key(evt[13]), .busy(busy), .branch_taken(branch_taken));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rv,
        output logic ev);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rv;
        logic ev;
        apb(1'b1, a, d, rv, ev);
    endtask : wr
    task automatic run(input bci_row_t w);
        int n;
        n = 0;
        wr(`BCI_ADDR_DATA, w.d);
        wr(`BCI_ADDR_CMD, {w.p, 1'b0, w.code, w.op});
        wr(`BCI_ADDR_CTRL, 32'h1);
        @(posedge pclk);
        while (busy === 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(n), 32'(w.t) * CPU);
        apb(1'b0, `BCI_ADDR_TIME, 32'h0, r, e);
        chk(r, {16'h0, w.t});
        if (w.tk != 2'd2) begin
            apb(1'b0, `BCI_ADDR_STAT, 32'h0, r, e);
            chk({31'h0, r[1]}, {31'h0, w.tk[0]});
        end
        // taken goes to P, otherwise falls through to the next instruction
        nxt = (w.tk == 2'd1) ? w.p : 20'(nxt + `BCI_SEQ_STEP);
        apb(1'b0, `BCI_ADDR_NEXT, 32'h0, r, e);
        chk(r, {12'h0, nxt});
    endtask : run
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h0);
        apb(1'b0, `BCI_ADDR_STAT, 32'h0, r, e); chk(r, 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e); chk(r, 32'h0); chk({31'h0, e}, 32'h1);
        $display("test reset done");
        foreach (rows[i]) run(rows[i]);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        $display("test table done");
        u_console.pulse(0);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h00080040);
        run('{BCI_OPC_IND_ON, 7'd6, 20'h00300, 32'h0, 2'd1, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(1); u_console.pulse(2); wr(`BCI_ADDR_CTRL, 32'h4);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h00000200);
        wr(`BCI_ADDR_CTRL, 32'h2);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(12); wr(`BCI_ADDR_CTRL, 32'h2);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h02080000);
        u_console.pulse(13);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(7);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h00000090);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h00080000);
        u_console.pulse(10);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h0);
        u_console.pulse(5);
        run('{BCI_OPC_IND_ON, 7'd16, 20'h00302, 32'h0, 2'd1, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(3); u_console.pulse(4); u_console.pulse(6);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h000AC000);
        run('{BCI_OPC_IND_ON, 7'd14, 20'h00304, 32'h0, 2'd1, 16'd60});
        run('{BCI_OPC_IND_ON, 7'd15, 20'h00306, 32'h0, 2'd1, 16'd60});
        run('{BCI_OPC_IND_OFF, 7'd17, 20'h00308, 32'h0, 2'd0, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(11);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h02080000);
        wr(`BCI_ADDR_CTRL, 32'h2);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        u_console.pulse(8); u_console.pulse(9);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h000000E0);
        wr(`BCI_ADDR_CTRL, 32'h4);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h0);
        u_console.set_switch(4'h1);
        run('{BCI_OPC_IND_ON, 7'd1, 20'h0030A, 32'h0, 2'd1, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, 32'h40000002);
        u_console.set_switch(4'hA);
        run('{BCI_OPC_SELECT, 7'd0, 20'h0030C, 32'h6, 2'd1, 16'd60});
        run('{BCI_OPC_IND_ON, 7'd31, 20'h0030E, 32'h0, 2'd1, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, 32'h80000014);
        apb(1'b0, `BCI_ADDR_IND_HI, 32'h0, r, e); chk(r, 32'h00000001);
        run('{BCI_OPC_SELECT, 7'd0, 20'h00310, 32'h1, 2'd1, 16'd60});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        run('{BCI_OPC_ARITH, 7'd0, 20'h00312, 32'h00080000, 2'd0, `BCI_T_PSTEP});
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE | 32'h00003000);
        wr(`BCI_ADDR_CTRL, 32'h2);
        apb(1'b0, `BCI_ADDR_IND_LO, 32'h0, r, e); chk(r, BASE);
        $display("test indicators done");
        report_and_stop();
    end
endmodule : tb_branch_condition_indicators
bind bci_core bci_core_sva #(.CYC_PER_UNIT(CYC_PER_UNIT)) u_sva (.*);
